// [boot_memory_model.sv]
// Byte-wide boot memory that answers each byte request with a level acknowledge
`timescale 1ns/1ps
`default_nettype none
module boot_memory_model #(
  parameter int DELAY = 3  // Access time in cycles, raise it for a slow part
) (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic boot_req_i,
  output logic      boot_ack_o
);
  logic [3:0] wait_q;  // Access time counter

  // Ready rises after the access time and falls only once the request drops,
  // so the block must see a full handshake for every byte
  always_ff @(posedge clk_i) begin
    if (sys_rst_i || !boot_req_i) begin
      wait_q     <= 4'h0;
      boot_ack_o <= 1'h0;
    end else if (wait_q == DELAY[3:0]) begin
      boot_ack_o <= 1'h1;
    end else begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule : boot_memory_model
`default_nettype wire

// [program_memory_overlay_map.sv]
// Program memory overlay decode, clock output, master reset and boot sequencing
`timescale 1ns/1ps
`default_nettype none
`include "program_memory_overlay_map_regs.svh"
module program_memory_overlay_map
  import program_memory_overlay_map_pkg::*;
#(
  parameter int BOOT_BYTES  = 96,   // Bytes fetched by the boot loader
  parameter int STACK_DEPTH = 12    // Mode stack entries
) (
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic        boot_disable_strap_i, // Mode strap pin
  input  wire logic        bus_request_i,        // External bus request pin
  input  wire logic        host_mode_i,          // Host memory mode pin
  input  wire logic        boot_ack_i,           // Boot memory byte ready pin
  input  wire logic [7:0]  reg_addr_i,
  input  wire logic [15:0] reg_wdata_i,
  input  wire logic        reg_wr_i,
  input  wire logic        reg_rd_i,
  output logic      [15:0] reg_rdata_o,
  input  wire logic        pm_fetch_req_i,
  input  wire logic [13:0] pm_fetch_addr_i,
  input  wire logic        pm_data_req_i,
  input  wire logic [13:0] pm_data_addr_i,
  input  wire logic        dm_req_i,
  input  wire logic [13:0] dm_addr_i,
  input  wire logic        io_req_i,
  input  wire logic [10:0] io_addr_i,
  input  wire logic        irq_entry_i,          // Core enters an interrupt
  input  wire logic        irq_exit_i,           // Core returns from an interrupt
  output logic             processor_clock_output_o,
  output logic             cycle_en_o,           // One processor cycle done
  output logic             fetch_internal_o,
  output logic             pm_data_internal_o,
  output logic             fetch_stall_o,        // Fetch lost the external bus
  output logic             dm_ctrl_reg_o,        // Data address hits a control register
  output logic             ext_sel_o,
  output logic      [13:0] ext_addr_o,
  output logic      [7:0]  ext_page_o,           // Extra byte address lines
  output logic             ext_data_oe_o,
  output logic             boot_req_o,
  output logic             core_run_o,
  output logic      [13:0] core_start_pc_o
);
  localparam int SPW = $clog2(STACK_DEPTH + 1);
  localparam int BCW = $clog2(BOOT_BYTES + 1);

  // Pin synchronisers: first stage feeds only the second
  logic [3:0] pin_meta_q;     // First stage
  logic [3:0] pin_sync_q;     // Second stage, the only one read
  always_ff @(posedge clk_i) begin
    pin_meta_q <= {boot_ack_i, host_mode_i, bus_request_i, boot_disable_strap_i};
    pin_sync_q <= pin_meta_q;
  end
  wire logic strap_s    = pin_sync_q[0];
  wire logic busreq_s   = pin_sync_q[1];
  wire logic host_s     = pin_sync_q[2];
  wire logic boot_ack_s = pin_sync_q[3];

  // Clock divider: phase of the input clock period in core ticks
  logic [1:0] div_q, div_d;
  logic       processor_clock_output_q, processor_clock_output_d;
  logic       cyc_en_q, cyc_en_d;
  logic       clk_dis_q, clk_dis_d; // clock_output_disable
  always_comb begin
    div_d    = div_q + 2'h1;
    cyc_en_d = (div_d[0] == 1'b1);
    // Restarts on the first tick after any reset, with no settling wait
    processor_clock_output_d = clk_dis_q ? 1'b0 : ~processor_clock_output_q;
  end
  always_ff @(posedge clk_i) begin
    div_q    <= sys_rst_i ? 2'h0 : div_d;
    cyc_en_q <= sys_rst_i ? 1'b0 : cyc_en_d;
    processor_clock_output_q <= sys_rst_i ? 1'b0 : processor_clock_output_d;
  end

  // Software visible control state
  logic [1:0]  ovl_q, ovl_d;        // program_overlay_select
  logic [15:0] msw_q, msw_d;        // mode_status_word
  logic [15:0] imask_q, imask_d;
  logic        mode_b_q, mode_b_d; // Strap level caught at reset
  logic [SPW-1:0] sp_q, sp_d;      // Mode stack pointer
  logic [15:0] stk_q [STACK_DEPTH];
  logic [15:0] stk_d [STACK_DEPTH];
  logic [15:0] rdata_q, rdata_d;
  seq_state_t  st_q, st_d;
  logic [BCW-1:0] bcnt_q, bcnt_d;

  // Register writes, mode stack and read data
  always_comb begin
    ovl_d     = ovl_q;
    clk_dis_d = clk_dis_q;
    msw_d     = msw_q;
    imask_d   = imask_q;
    sp_d      = sp_q;
    stk_d     = stk_q;
    mode_b_d  = (sys_rst_i || st_q == ST_RESET) ? strap_s : mode_b_q;
    rdata_d   = 16'h0000;
    if (reg_wr_i) begin
      if (reg_addr_i == `REG_OVERLAY_SELECT) begin
        // Only overlays 0..2 exist; strap high pins it to zero
        if (!mode_b_q && reg_wdata_i[1:0] != 2'h3) ovl_d = reg_wdata_i[1:0];
      end else if (reg_addr_i == `REG_CLOCK_CONTROL) begin
        clk_dis_d = reg_wdata_i[`CLOCK_OUTPUT_DISABLE_BIT];
      end else if (reg_addr_i == `REG_MODE_STATUS) begin
        msw_d = reg_wdata_i;
      end else if (reg_addr_i == `REG_INTERRUPT_MASK) begin
        imask_d = reg_wdata_i;
      end
    end
    // Interrupt entry saves the status word only, never the overlay
    if (irq_entry_i && sp_q < SPW'(STACK_DEPTH)) begin
      stk_d[sp_q] = msw_q;
      sp_d        = sp_q + SPW'(1);
    end else if (irq_exit_i && sp_q != '0) begin
      msw_d = stk_q[sp_q - SPW'(1)];
      sp_d  = sp_q - SPW'(1);
    end
    if (reg_rd_i) begin
      if (reg_addr_i == `REG_OVERLAY_SELECT) begin
        rdata_d = {14'h0000, ovl_q};
      end else if (reg_addr_i == `REG_CLOCK_CONTROL) begin
        rdata_d = {15'h0000, clk_dis_q};
      end else if (reg_addr_i == `REG_MODE_STATUS) begin
        rdata_d = msw_q;
      end else if (reg_addr_i == `REG_INTERRUPT_MASK) begin
        rdata_d = imask_q;
      end else if (reg_addr_i == `REG_BLOCK_STATUS) begin
        rdata_d = {13'h0000, (st_q == ST_RUN && !mode_b_q), (st_q == ST_RUN), mode_b_q};
      end else if (reg_addr_i == `REG_STACK_POINTER) begin
        rdata_d = 16'(sp_q);
      end else begin
        rdata_d = 16'h0000;       // Unmapped reads return zero
      end
    end
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      ovl_q     <= `OVERLAY_RESET;
      clk_dis_q <= 1'b0;
      msw_q     <= `MODE_STATUS_RESET;
      imask_q   <= `INTERRUPT_MASK_RESET;
      sp_q      <= SPW'(`STACK_EMPTY);
      rdata_q   <= 16'h0000;
    end else begin
      ovl_q     <= mode_b_q ? `OVERLAY_RESET : ovl_d;
      clk_dis_q <= clk_dis_d;
      msw_q     <= msw_d;
      imask_q   <= imask_d;
      sp_q      <= sp_d;
      rdata_q   <= rdata_d;
    end
    mode_b_q <= mode_b_d;
    stk_q    <= stk_d;
  end

  // Sequencer: hold off on bus request, boot, then run from zero
  always_comb begin
    st_d   = st_q;
    bcnt_d = bcnt_q;
    case (st_q)
      ST_RESET: begin
        st_d = ST_HOLD;
      end
      ST_HOLD: begin
        if (!busreq_s) begin
          st_d = mode_b_q ? ST_RUN : ST_BOOT_REQ;
        end
      end
      ST_BOOT_REQ: begin
        if (boot_ack_s) begin
          bcnt_d = bcnt_q + BCW'(1);
          st_d   = ST_BOOT_WAIT;
        end
      end
      ST_BOOT_WAIT: begin
        // Wait for the acknowledge to drop before the next byte
        if (!boot_ack_s) begin
          st_d = (bcnt_q == BCW'(BOOT_BYTES)) ? ST_RUN : ST_BOOT_REQ;
        end
      end
      default: begin
        st_d = ST_RUN;
      end
    endcase
  end
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      st_q   <= ST_RESET;
      bcnt_q <= '0;
    end else begin
      st_q   <= st_d;
      bcnt_q <= bcnt_d;
    end
  end

  // Program address decode; the overlay takes effect at once with no loop interlock
  function automatic logic pm_is_internal(input logic [13:0] a, input logic mb,
                                          input logic [1:0] ov);
    if (mb) begin
      pm_is_internal = (a >= `PM_UPPER_BASE);
    end else begin
      pm_is_internal = (a < `PM_UPPER_BASE) || (ov == 2'h0);
    end
  endfunction : pm_is_internal

  // External bus owner and address; data access beats the fetch on a clash
  logic        f_int, d_int;
  ext_owner_t  owner;
  logic [13:0] eaddr_d;
  logic [7:0]  epage_d;
  always_comb begin
    f_int   = pm_is_internal(pm_fetch_addr_i, mode_b_q, ovl_q);
    d_int   = pm_is_internal(pm_data_addr_i, mode_b_q, ovl_q);
    owner   = EXT_NONE;
    eaddr_d = 14'h0000;
    epage_d = 8'h00;
    if (st_q == ST_BOOT_REQ) begin
      owner   = EXT_BOOT;
      eaddr_d = 14'(bcnt_q);
      epage_d = 8'(bcnt_q >> 14);
    end else if (st_q == ST_RUN && pm_data_req_i && !d_int) begin
      owner   = EXT_PM_DATA;
      eaddr_d = mode_b_q ? pm_data_addr_i
                         : {(ovl_q == 2'h2), pm_data_addr_i[12:0]};
    end else if (st_q == ST_RUN && pm_fetch_req_i && !f_int) begin
      owner   = EXT_PM_FETCH;
      eaddr_d = mode_b_q ? pm_fetch_addr_i
                         : {(ovl_q == 2'h2), pm_fetch_addr_i[12:0]};
    end else if (st_q == ST_RUN && io_req_i) begin
      owner   = EXT_IO;
      eaddr_d = {3'h0, io_addr_i};
    end
    if (host_s) begin
      eaddr_d = {13'h0000, eaddr_d[0]};
    end
  end

  // Output registers
  logic        fint_q, dint_q, stall_q, dmc_q, esel_q, eoe_q, breq_q, run_q;
  logic [13:0] eaddr_q;
  logic [7:0]  epage_q;
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      fint_q  <= 1'b0;
      dint_q  <= 1'b0;
      stall_q <= 1'b0;
      dmc_q   <= 1'b0;
      esel_q  <= 1'b0;
      eoe_q   <= 1'b0;
      breq_q  <= 1'b0;
      run_q   <= 1'b0;
      eaddr_q <= 14'h0000;
      epage_q <= 8'h00;
    end else begin
      fint_q  <= pm_fetch_req_i && f_int;
      dint_q  <= pm_data_req_i && d_int;
      stall_q <= pm_fetch_req_i && !f_int && owner != EXT_PM_FETCH;
      dmc_q   <= dm_req_i && dm_addr_i >= `DM_CTRL_BASE;
      esel_q  <= owner != EXT_NONE;
      eoe_q   <= owner != EXT_NONE && owner != EXT_BOOT && host_s;
      breq_q  <= st_d == ST_BOOT_REQ;
      run_q   <= st_d == ST_RUN;
      eaddr_q <= eaddr_d;
      epage_q <= epage_d;
    end
  end
  assign reg_rdata_o              = rdata_q;
  assign processor_clock_output_o = processor_clock_output_q;
  assign cycle_en_o               = cyc_en_q;
  assign fetch_internal_o         = fint_q;
  assign pm_data_internal_o       = dint_q;
  assign fetch_stall_o            = stall_q;
  assign dm_ctrl_reg_o            = dmc_q;
  assign ext_sel_o                = esel_q;
  assign ext_addr_o               = eaddr_q;
  assign ext_page_o               = epage_q;
  assign ext_data_oe_o            = eoe_q;
  assign boot_req_o               = breq_q;
  assign core_run_o               = run_q;
  assign core_start_pc_o          = `PM_FIRST_FETCH;

  // Checks
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  a_cycle_half_rate: assert property (cyc_en_q |=> !cyc_en_q ##1 cyc_en_q)
    else $error("processor cycle enable not every second tick");
  a_processor_clock_output_gated: assert property (clk_dis_q |=> !processor_clock_output_q)
    else $error("clock output runs while disabled");
  a_processor_clock_output_runs: assert property (!clk_dis_q && !$past(clk_dis_q) && !$past(sys_rst_i)
    |-> processor_clock_output_q != $past(processor_clock_output_q))
    else $error("clock output stopped while enabled");
  a_reset_clears: assert property ($fell(sys_rst_i) |-> msw_q == 16'h0000 && imask_q == 16'h0000 && sp_q == '0)
    else $error("master reset left state behind");
  a_strap_no_ovl: assert property (mode_b_q |-> ovl_q == 2'h0)
    else $error("overlay nonzero with boot disabled");
  a_ovl_upper_ext: assert property (st_q == ST_RUN && !mode_b_q && ovl_q != 2'h0 && pm_data_req_i
    && pm_data_addr_i >= 14'h2000 |=> esel_q && !dint_q)
    else $error("upper program access not sent external");
  a_ovl_bit13: assert property (st_q == ST_RUN && !host_s && !mode_b_q && ovl_q != 2'h0 && pm_data_req_i
    && pm_data_addr_i >= 14'h2000 |=> ext_addr_o[13] == ($past(ovl_q) == 2'h2))
    else $error("overlay address bit 13 wrong");
  a_zero_internal: assert property (!mode_b_q && ovl_q == 2'h0 && pm_fetch_req_i |=> fint_q)
    else $error("fetch not internal with overlay zero");
  a_strap_map: assert property (mode_b_q && pm_fetch_req_i && pm_fetch_addr_i < 14'h2000 |=> !fint_q)
    else $error("lower half internal with boot disabled");
  a_host_addr: assert property (host_s && $past(host_s) |=> ext_addr_o[13:1] == 13'h0000)
    else $error("host mode drove high address bits");
  a_dm_ctrl: assert property (dm_req_i && dm_addr_i < 14'h3fe0 |=> !dmc_q)
    else $error("user data word flagged as register");
  a_stack_keeps_ovl: assert property (irq_entry_i && !reg_wr_i |=> ovl_q == $past(ovl_q))
    else $error("interrupt entry changed overlay");
  c_boot_done: cover property (st_q == ST_BOOT_WAIT ##1 st_q == ST_RUN);
  c_overlay_two: cover property (ovl_q == 2'h2 && esel_q);
  c_fetch_stall: cover property (stall_q);
  c_host_access: cover property (host_s && esel_q);
endmodule : program_memory_overlay_map
`default_nettype wire

// [program_memory_overlay_map_pkg.sv]
// Types shared by the overlay map block
package program_memory_overlay_map_pkg;
  // Sequencing after master reset
  typedef enum logic [2:0] {
    ST_RESET, ST_HOLD, ST_BOOT_REQ, ST_BOOT_WAIT, ST_RUN
  } seq_state_t;
  // Owner of the external address bus
  typedef enum logic [2:0] {
    EXT_NONE, EXT_BOOT, EXT_PM_DATA, EXT_PM_FETCH, EXT_IO
  } ext_owner_t;
endpackage : program_memory_overlay_map_pkg

// [program_memory_overlay_map_regs.svh]
// Register offsets, field positions, reset values and timing counts of the overlay map block
`ifndef PROGRAM_MEMORY_OVERLAY_MAP_REGS_SVH
`define PROGRAM_MEMORY_OVERLAY_MAP_REGS_SVH
// Register offsets on the plain register port
`define REG_OVERLAY_SELECT   8'h00
`define REG_CLOCK_CONTROL    8'h01
`define REG_MODE_STATUS      8'h02
`define REG_INTERRUPT_MASK   8'h03
`define REG_BLOCK_STATUS     8'h04
`define REG_STACK_POINTER    8'h05
// Field positions
`define CLOCK_OUTPUT_DISABLE_BIT 0
`define STATUS_MODE_B_BIT        0
`define STATUS_RUNNING_BIT       1
`define STATUS_BOOTED_BIT        2
// Reset values
`define OVERLAY_RESET        2'h0
`define MODE_STATUS_RESET    16'h0000
`define INTERRUPT_MASK_RESET 16'h0000
`define STACK_EMPTY          4'h0
// Address map
`define PM_UPPER_BASE        14'h2000
`define PM_FIRST_FETCH       14'h0000
`define DM_CTRL_BASE         14'h3fe0
`define DM_USER_WORDS        16352
`define IO_SPACE_WORDS       2048
// Timing: core clock ticks per processor cycle and processor cycles per input clock period
`define CLKS_PER_CYCLE       2
`define CYCLES_PER_INPUT_CLK 2
`define PLL_LOCK_INPUT_CLKS  2000
`endif

// [tb.sv]
// Self-checking bench for the program memory overlay map block
`timescale 1ns/1ps
`default_nettype none
`include "program_memory_overlay_map_regs.svh"
module tb;
  typedef struct packed {
    logic [1:0]  ov;     // Overlay value written
    logic        dat;    // Use the program data port, else fetch
    logic [13:0] addr;   // Program address
    logic        intl;   // Expect internal RAM
    logic        ext;    // Expect external bus
    logic [13:0] eaddr;  // Expected external address
  } row_t;
  // Overlay 3 is refused, so the last row still sees overlay 2
  row_t rows [7] = '{
    '{2'h0, 1'h0, 14'h0000, 1'h1, 1'h0, 14'h0000},
    '{2'h0, 1'h1, 14'h3fff, 1'h1, 1'h0, 14'h0000},
    '{2'h1, 1'h0, 14'h2000, 1'h0, 1'h1, 14'h0000},
    '{2'h1, 1'h1, 14'h3fff, 1'h0, 1'h1, 14'h1fff},
    '{2'h2, 1'h0, 14'h2005, 1'h0, 1'h1, 14'h2005},
    '{2'h2, 1'h1, 14'h1fff, 1'h1, 1'h0, 14'h0000},
    '{2'h3, 1'h0, 14'h2001, 1'h0, 1'h1, 14'h2001}};
  logic        clk_i, sys_rst_i, strap, bus_request, host_mode, boot_ack;
  logic [7:0]  reg_addr;
  logic [15:0] reg_wdata, rdata, d;
  logic        reg_wr, reg_rd, fetch_req, data_req, dm_req, io_req, irq_entry, irq_exit;
  logic [13:0] fetch_addr, data_addr, dm_addr, ext_addr, start_pc;
  logic [10:0] io_addr;
  logic [7:0]  ext_page;
  logic        pclk, cycle_en, fetch_int, data_int, stall, dm_ctrl, ext_sel, ext_oe;
  logic        boot_req, core_run, boot_seen;
  int          n_mismatch, n_tests;

  program_memory_overlay_map #(.BOOT_BYTES(4)) dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .boot_disable_strap_i(strap),
    .bus_request_i(bus_request), .host_mode_i(host_mode), .boot_ack_i(boot_ack),
    .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd),
    .reg_rdata_o(rdata), .pm_fetch_req_i(fetch_req), .pm_fetch_addr_i(fetch_addr),
    .pm_data_req_i(data_req), .pm_data_addr_i(data_addr), .dm_req_i(dm_req),
    .dm_addr_i(dm_addr), .io_req_i(io_req), .io_addr_i(io_addr), .irq_entry_i(irq_entry),
    .irq_exit_i(irq_exit), .processor_clock_output_o(pclk), .cycle_en_o(cycle_en),
    .fetch_internal_o(fetch_int), .pm_data_internal_o(data_int), .fetch_stall_o(stall),
    .dm_ctrl_reg_o(dm_ctrl), .ext_sel_o(ext_sel), .ext_addr_o(ext_addr),
    .ext_page_o(ext_page), .ext_data_oe_o(ext_oe), .boot_req_o(boot_req),
    .core_run_o(core_run), .core_start_pc_o(start_pc));

  boot_memory_model #(.DELAY(5)) mem (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .boot_req_i(boot_req), .boot_ack_o(boot_ack));

  // Core clock, 20 ns period
  initial begin
    clk_i = 1'h0;
    forever #10 clk_i = ~clk_i;
  end

  // Remember that a boot byte was ever requested
  always @(posedge clk_i) begin
    if (boot_req === 1'h1) begin
      boot_seen <= 1'h1;
    end
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge clk_i);
    reg_wr    <= 1'h1;
    reg_addr  <= a;
    reg_wdata <= v;
    @(posedge clk_i);
    reg_wr <= 1'h0;
  endtask : wr

  // Read data stand only in the cycle after the strobe
  task automatic rd(input logic [7:0] a, output logic [15:0] v);
    @(posedge clk_i);
    reg_rd   <= 1'h1;
    reg_addr <= a;
    @(posedge clk_i);
    reg_rd <= 1'h0;
    #1;
    v = rdata;
  endtask : rd

  // One program access, outputs looked at in the answer cycle
  task automatic acc(input logic f, input logic dt, input logic [13:0] a);
    @(posedge clk_i);
    fetch_req  <= f;
    data_req   <= dt;
    fetch_addr <= a;
    data_addr  <= a;
    @(posedge clk_i);
    fetch_req <= 1'h0;
    data_req  <= 1'h0;
    #1;
  endtask : acc

  task automatic pulse(input logic ent);
    @(posedge clk_i);
    irq_entry <= ent;
    irq_exit  <= !ent;
    @(posedge clk_i);
    irq_entry <= 1'h0;
    irq_exit  <= 1'h0;
  endtask : pulse

  // Clock output toggles every tick when enabled, cycle pulse every second tick
  task automatic clk_run(input logic en);
    logic pp, pc;
    repeat (2) @(posedge clk_i);
    #1;
    pp = pclk;
    pc = cycle_en;
    repeat (4) begin
      @(posedge clk_i);
      #1;
      check(16'(pclk), 16'(en ? !pp : 1'h0));
      check(16'(cycle_en), 16'(!pc));
      pp = pclk;
      pc = cycle_en;
    end
  endtask : clk_run

  task automatic results;
    $display("comparisons %0d mismatches %0d", n_tests, n_mismatch);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results

  initial begin
    #1000000;  // Power-up hold plus all tests, with a wide margin
    n_mismatch++;
    results();
  end

  initial begin
    {strap, bus_request, host_mode, reg_wr, reg_rd, fetch_req, data_req} = '0;
    {dm_req, io_req, irq_entry, irq_exit, boot_seen} = '0;
    {reg_addr, reg_wdata, fetch_addr, data_addr, dm_addr, io_addr} = '0;
    sys_rst_i = 1'h1;
    // Power-up hold: the lock wait in input clocks, four core ticks each
    repeat (`PLL_LOCK_INPUT_CLKS * `CYCLES_PER_INPUT_CLK * `CLKS_PER_CYCLE)
      @(posedge clk_i);
    sys_rst_i <= 1'h0;
    rd(`REG_MODE_STATUS, d);
    check(d, 16'h0000);
    rd(`REG_INTERRUPT_MASK, d);
    check(d, 16'h0000);
    rd(`REG_STACK_POINTER, d);
    check(d, 16'h0000);
    check(16'(start_pc), 16'h0000);
    repeat (3000) if (core_run !== 1'h1) @(posedge clk_i);
    check(16'(core_run), 16'h0001);
    check(16'(boot_seen), 16'h0001);
    rd(`REG_BLOCK_STATUS, d);
    check(16'(d[`STATUS_BOOTED_BIT]), 16'h0001);
    $display("boot test done");
    foreach (rows[i]) begin
      wr(`REG_OVERLAY_SELECT, 16'(rows[i].ov));
      acc(!rows[i].dat, rows[i].dat, rows[i].addr);
      check(16'(rows[i].dat ? data_int : fetch_int), 16'(rows[i].intl));
      check(16'(ext_sel), 16'(rows[i].ext));
      if (rows[i].ext) check(16'(ext_addr), 16'(rows[i].eaddr));
    end
    acc(1'h1, 1'h1, 14'h2010);
    check(16'(stall), 16'h0001);
    check(16'(ext_addr), 16'h2010);
    wr(`REG_OVERLAY_SELECT, 16'h0000);
    acc(1'h1, 1'h1, 14'h2100);
    check(16'(fetch_int), 16'h0001);
    check(16'(data_int), 16'h0001);
    check(16'(stall), 16'h0000);
    $display("decode test done");
    clk_run(1'h1);
    wr(`REG_CLOCK_CONTROL, 16'h0001);
    clk_run(1'h0);
    wr(`REG_CLOCK_CONTROL, 16'h0000);
    $display("clock test done");
    wr(`REG_MODE_STATUS, 16'h1234);
    wr(`REG_OVERLAY_SELECT, 16'h0001);
    pulse(1'h1);
    rd(`REG_STACK_POINTER, d);
    check(d, 16'h0001);
    wr(`REG_MODE_STATUS, 16'h0000);
    wr(`REG_OVERLAY_SELECT, 16'h0002);
    pulse(1'h0);
    rd(`REG_MODE_STATUS, d);
    check(d, 16'h1234);
    rd(`REG_OVERLAY_SELECT, d);
    check(d, 16'h0002);
    rd(8'h3f, d);
    check(d, 16'h0000);
    $display("stack test done");
    host_mode <= 1'h1;
    repeat (4) @(posedge clk_i);
    acc(1'h1, 1'h0, 14'h2003);
    check(16'(ext_addr), 16'h0001);
    check(16'(ext_oe), 16'h0001);
    @(posedge clk_i);
    host_mode <= 1'h0;
    dm_req  <= 1'h1;
    dm_addr <= 14'h3fdf;
    @(posedge clk_i);
    dm_addr <= 14'h3fe0;
    #1;
    check(16'(dm_ctrl), 16'h0000);
    @(posedge clk_i);
    dm_req <= 1'h0;
    #1;
    check(16'(dm_ctrl), 16'h0001);
    repeat (4) @(posedge clk_i);
    io_req  <= 1'h1;
    io_addr <= 11'h7ff;
    @(posedge clk_i);
    io_req <= 1'h0;
    #1;
    check(16'(ext_sel), 16'h0001);
    check(16'(ext_addr[10:0]), 16'h07ff);
    check(16'(ext_page), 16'h0000);
    $display("space test done");
    // Leave state behind so the later reset has something to clear
    wr(`REG_INTERRUPT_MASK, 16'hffff);
    pulse(1'h1);
    @(posedge clk_i);
    sys_rst_i   <= 1'h1;
    strap       <= 1'h1;
    bus_request <= 1'h1;
    boot_seen = 1'h0;
    repeat (6) @(posedge clk_i);
    sys_rst_i <= 1'h0;
    clk_run(1'h1);
    check(16'(core_run), 16'h0000);
    @(posedge clk_i);
    bus_request <= 1'h0;
    repeat (6) @(posedge clk_i);
    #1;
    check(16'(core_run), 16'h0001);
    check(16'(boot_seen), 16'h0000);
    rd(`REG_MODE_STATUS, d);
    check(d, 16'h0000);
    rd(`REG_STACK_POINTER, d);
    check(d, 16'h0000);
    rd(`REG_INTERRUPT_MASK, d);
    check(d, 16'h0000);
    wr(`REG_OVERLAY_SELECT, 16'h0001);
    rd(`REG_OVERLAY_SELECT, d);
    check(d, 16'h0000);
    acc(1'h1, 1'h0, 14'h0005);
    check(16'(ext_sel), 16'h0001);
    check(16'(ext_addr), 16'h0005);
    acc(1'h1, 1'h0, 14'h2005);
    check(16'(fetch_int), 16'h0001);
    check(16'(ext_sel), 16'h0000);
    $display("strap test done");
    results();
  end
endmodule : tb
`default_nettype wire
